/* File: rtl/omc_regs.vh */
// Mode codes, channel layout and reset values for the operation mode controller.
`ifndef OMC_REGS_VH
`define OMC_REGS_VH
`define OMC_NCH 8
`define OMC_NIN 2
`define OMC_MODE_SLEEP 2'h0
`define OMC_MODE_LIMP 2'h1
`define OMC_MODE_IDLE 2'h2
`define OMC_MODE_ACTIVE 2'h3
`define OMC_ST_SLEEP 4'h1
`define OMC_ST_IDLE 4'h2
`define OMC_ST_ACTIVE 4'h4
`define OMC_ST_LIMP 4'h8
`define OMC_LIMP_CH_MASK 8'h0c
`define OMC_MAP_A_RST 8'h04
`define OMC_MAP_B_RST 8'h08
`define OMC_OUT_RST 8'h00
`endif

/* File: rtl/omc_mode_ctrl.v */
// Operation mode and register reset controller for a relay and load driver.
//
// Overview of operation
// - Sleep: outputs off, registers held at reset.
// - Idle: outputs off, no diagnosis, registers usable.
// - Idle keeps latched channel error bits except in logic undervoltage.
// - Active when idle pin high and input/out bit.
// - Without stay-active, Active returns Idle when quiet.
// - Stay-active bit holds Active mode.
// - Logic undervoltage, inputs low: Active goes Idle.
// - Any high input enters Active regardless mapping.
// - Idle pin low, input high: Limp Home.
// - Limp Home ignores register writes.
// - Limp entry sets both supply flags, mode 01.
// - First command in Limp flags transmission error.
// - Limp: open-load flags zero, status and error bits still live.
// - Limp drives only channels 2 and 3.
// - Registers reset on logic UV, idle low, soft reset.
// - Soft reset keeps errors, clears supply flags.
// - Register reset: channels off unless input high.
// - Analog undervoltage sets supply undervoltage flag.
// - Supply flag clears after diagnosis readout once good.
// - Power-on needs supply good plus input or idle.
// - Logic low flag follows low range, clears on readout.
`timescale 1ns/1ns
`include "omc_regs.vh"

module omc_mode_ctrl (
    input wire clk_sys_i,
    input wire srst_i,
    input wire idle_pin_i,
    input wire [`OMC_NIN-1:0] direct_input_pins_i,
    input wire vs_uv_i,
    input wire vs_op_i,
    input wire vdd_uv_i,
    input wire vdd_lop_i,
    input wire reg_wr_i,
    input wire [`OMC_NCH-1:0] wr_output_on_bits_i,
    input wire wr_stay_active_bit_i,
    input wire wr_soft_reset_bit_i,
    input wire [`OMC_NCH-1:0] wr_input_mapping_a_i,
    input wire [`OMC_NCH-1:0] wr_input_mapping_b_i,
    input wire spi_cmd_i,
    input wire diag_readout_i,
    input wire [`OMC_NCH-1:0] channel_error_set_i,
    input wire [`OMC_NCH-1:0] channel_error_clr_i,
    input wire open_load_on_i,
    input wire open_load_off_i,
    input wire [`OMC_NCH-1:0] output_status_i,
    output reg [1:0] mode_o,
    output reg power_on_o,
    output reg diag_enable_o,
    output reg spi_access_o,
    output reg [`OMC_NCH-1:0] channel_on_o,
    output reg [`OMC_NCH-1:0] output_on_bits_o,
    output reg stay_active_bit_o,
    output reg [`OMC_NCH-1:0] input_mapping_a_o,
    output reg [`OMC_NCH-1:0] input_mapping_b_o,
    output reg supply_undervoltage_flag_o,
    output reg logic_supply_low_flag_o,
    output reg transmission_error_flag_o,
    output reg open_load_on_flag_o,
    output reg open_load_off_flag_o,
    output reg [`OMC_NCH-1:0] channel_error_latches_o,
    output reg [`OMC_NCH-1:0] output_status_monitor_bits_o
);

    // Pin inputs pass three flops; a change counts once stages two and three agree.
    reg [2:0] idle_sync_r;
    reg [2:0] in0_sync_r;
    reg [2:0] in1_sync_r;
    reg [2:0] vsuv_sync_r;
    reg [2:0] vsop_sync_r;
    reg [2:0] vdduv_sync_r;
    reg [2:0] vddlop_sync_r;
    reg idle_r;
    reg [`OMC_NIN-1:0] in_r;
    reg vs_uv_r;
    reg vs_op_r;
    reg vdd_uv_r;
    reg vdd_lop_r;
    reg [3:0] state_r;
    reg [3:0] state_nxt;
    reg limp_first_r;

    function filt;
        input [2:0] s;
        input cur;
        begin
            filt = (s[1] == s[2]) ? s[2] : cur;
        end
    endfunction

    // Channels selected by the direct inputs through two mapping words.
    function [`OMC_NCH-1:0] chan_map;
        input [`OMC_NIN-1:0] pins;
        input [`OMC_NCH-1:0] map_a;
        input [`OMC_NCH-1:0] map_b;
        begin
            chan_map = (pins[0] ? map_a : `OMC_OUT_RST) | (pins[1] ? map_b : `OMC_OUT_RST);
        end
    endfunction

    // Mode field code for a one-hot state.
    function [1:0] mode_code;
        input [3:0] st;
        begin
            case (st)
                `OMC_ST_LIMP: mode_code = `OMC_MODE_LIMP;
                `OMC_ST_IDLE: mode_code = `OMC_MODE_IDLE;
                `OMC_ST_ACTIVE: mode_code = `OMC_MODE_ACTIVE;
                default: mode_code = `OMC_MODE_SLEEP;
            endcase
        end
    endfunction

    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            idle_sync_r <= 3'h0;
            in0_sync_r <= 3'h0;
            in1_sync_r <= 3'h0;
            vsuv_sync_r <= 3'h0;
            vsop_sync_r <= 3'h0;
            vdduv_sync_r <= 3'h0;
            vddlop_sync_r <= 3'h0;
        end else begin
            idle_sync_r <= {idle_sync_r[1:0], idle_pin_i};
            in0_sync_r <= {in0_sync_r[1:0], direct_input_pins_i[0]};
            in1_sync_r <= {in1_sync_r[1:0], direct_input_pins_i[1]};
            vsuv_sync_r <= {vsuv_sync_r[1:0], vs_uv_i};
            vsop_sync_r <= {vsop_sync_r[1:0], vs_op_i};
            vdduv_sync_r <= {vdduv_sync_r[1:0], vdd_uv_i};
            vddlop_sync_r <= {vddlop_sync_r[1:0], vdd_lop_i};
        end
    end

    // Filtered levels only move once the last two stages agree.
    // They reset low, so a pin already high after reset is seen as a fresh change.
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            idle_r <= 1'b0;
            in_r <= {`OMC_NIN{1'b0}};
            vs_uv_r <= 1'b0;
            vs_op_r <= 1'b0;
            vdd_uv_r <= 1'b0;
            vdd_lop_r <= 1'b0;
        end else begin
            idle_r <= filt(idle_sync_r, idle_r);
            in_r <= {filt(in1_sync_r, in_r[1]), filt(in0_sync_r, in_r[0])};
            vs_uv_r <= filt(vsuv_sync_r, vs_uv_r);
            vs_op_r <= filt(vsop_sync_r, vs_op_r);
            vdd_uv_r <= filt(vdduv_sync_r, vdd_uv_r);
            vdd_lop_r <= filt(vddlop_sync_r, vdd_lop_r);
        end
    end

    wire any_in = |in_r;
    wire any_out = |output_on_bits_o;
    // Register reset: logic supply missing, idle pin low, or soft reset command.
    wire soft_rst = reg_wr_i && wr_soft_reset_bit_i && (state_r != `OMC_ST_LIMP)
        && (state_r != `OMC_ST_SLEEP);
    wire hard_rst = vdd_uv_r || !idle_r || (state_r == `OMC_ST_SLEEP);
    wire wr_ok = reg_wr_i && !wr_soft_reset_bit_i && !hard_rst
        && (state_r != `OMC_ST_LIMP);
    // Channel each input drives, from the current mapping.
    wire [`OMC_NCH-1:0] in_map = chan_map(in_r, input_mapping_a_o, input_mapping_b_o);
    // Limp Home ignores the programmed mapping and may only reach channels 2 and 3.
    wire [`OMC_NCH-1:0] limp_map = chan_map(in_r, `OMC_MAP_A_RST, `OMC_MAP_B_RST)
        & `OMC_LIMP_CH_MASK;
    // The cycle in which the state machine steps into Limp Home.
    wire limp_entry = (state_nxt == `OMC_ST_LIMP) && (state_r != `OMC_ST_LIMP);

    always @* begin
        state_nxt = state_r;
        case (state_r)
            `OMC_ST_SLEEP: begin
                if (idle_r && (any_in || any_out))
                    state_nxt = `OMC_ST_ACTIVE;
                else if (idle_r)
                    state_nxt = `OMC_ST_IDLE;
                else if (any_in)
                    state_nxt = `OMC_ST_LIMP;
            end
            `OMC_ST_IDLE: begin
                if (!idle_r && any_in)
                    state_nxt = `OMC_ST_LIMP;
                else if (!idle_r)
                    state_nxt = `OMC_ST_SLEEP;
                else if (any_in || any_out || stay_active_bit_o)
                    state_nxt = `OMC_ST_ACTIVE;
            end
            `OMC_ST_ACTIVE: begin
                if (!idle_r && any_in)
                    state_nxt = `OMC_ST_LIMP;
                else if (!idle_r)
                    state_nxt = `OMC_ST_SLEEP;
                else if (vdd_uv_r && !any_in)
                    state_nxt = `OMC_ST_IDLE;
                else if (!stay_active_bit_o && !any_in && !any_out)
                    state_nxt = `OMC_ST_IDLE;
            end
            `OMC_ST_LIMP: begin
                if (idle_r)
                    state_nxt = (any_in || any_out) ? `OMC_ST_ACTIVE : `OMC_ST_IDLE;
                else if (!any_in)
                    state_nxt = `OMC_ST_SLEEP;
            end
            default: state_nxt = `OMC_ST_SLEEP;
        endcase
    end

    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_r <= `OMC_ST_SLEEP;
            mode_o <= `OMC_MODE_SLEEP;
            power_on_o <= 1'b0;
            diag_enable_o <= 1'b0;
            spi_access_o <= 1'b0;
            output_status_monitor_bits_o <= `OMC_OUT_RST;
        end else begin
            state_r <= state_nxt;
            // Power-on needs an operative analog supply or a logic supply above its low range.
            power_on_o <= (vs_op_r || (!vdd_lop_r && !vdd_uv_r)) && (any_in || idle_r);
            mode_o <= mode_code(state_nxt);
            diag_enable_o <= (state_nxt == `OMC_ST_ACTIVE);
            spi_access_o <= !vdd_uv_r && ((state_nxt == `OMC_ST_IDLE)
                || (state_nxt == `OMC_ST_ACTIVE) || (state_nxt == `OMC_ST_LIMP));
            output_status_monitor_bits_o <= (state_nxt == `OMC_ST_SLEEP)
                ? `OMC_OUT_RST : output_status_i;
        end
    end

    // Channel outputs per mode; Idle and Sleep hold them all off.
    // Active mixes the programmed bits with the mapped inputs; analog undervoltage drops the bits.
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            channel_on_o <= `OMC_OUT_RST;
        end else begin
            case (state_nxt)
                `OMC_ST_ACTIVE: channel_on_o <= (vs_uv_r ? `OMC_OUT_RST
                    : output_on_bits_o) | in_map;
                `OMC_ST_LIMP: channel_on_o <= limp_map;
                default: channel_on_o <= `OMC_OUT_RST;
            endcase
        end
    end

    // Configuration registers; any register reset or Limp Home restores defaults.
    // Writes refused in Limp Home, Sleep or a register reset leave no trace.
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            output_on_bits_o <= `OMC_OUT_RST;
            stay_active_bit_o <= 1'b0;
            input_mapping_a_o <= `OMC_MAP_A_RST;
            input_mapping_b_o <= `OMC_MAP_B_RST;
        end else begin
            if (hard_rst || soft_rst || state_r == `OMC_ST_LIMP) begin
                output_on_bits_o <= `OMC_OUT_RST;
                stay_active_bit_o <= 1'b0;
                input_mapping_a_o <= `OMC_MAP_A_RST;
                input_mapping_b_o <= `OMC_MAP_B_RST;
            end else if (wr_ok) begin
                output_on_bits_o <= wr_output_on_bits_i;
                stay_active_bit_o <= wr_stay_active_bit_i;
                input_mapping_a_o <= wr_input_mapping_a_i;
                input_mapping_b_o <= wr_input_mapping_b_i;
            end
        end
    end

    // Error latches: set wins over clear; soft reset keeps them, Sleep or logic undervoltage resets them.
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            channel_error_latches_o <= `OMC_OUT_RST;
        end else begin
            if (state_r == `OMC_ST_SLEEP || vdd_uv_r)
                channel_error_latches_o <= `OMC_OUT_RST;
            else
                channel_error_latches_o <= channel_error_set_i | (channel_error_latches_o
                    & ~(wr_ok ? channel_error_clr_i : `OMC_OUT_RST));
        end
    end

    // Open-load flags only live in Active.
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            open_load_on_flag_o <= 1'b0;
            open_load_off_flag_o <= 1'b0;
        end else begin
            if (state_nxt != `OMC_ST_ACTIVE) begin
                open_load_on_flag_o <= 1'b0;
                open_load_off_flag_o <= 1'b0;
            end else begin
                open_load_on_flag_o <= open_load_on_i;
                open_load_off_flag_o <= open_load_off_i;
            end
        end
    end

    // Supply flags: set wins over clear.
    // Limp entry forces both up; otherwise a readout clears them once the supply is good.
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            supply_undervoltage_flag_o <= 1'b0;
            logic_supply_low_flag_o <= 1'b0;
        end else begin
            if (state_nxt == `OMC_ST_SLEEP) begin
                supply_undervoltage_flag_o <= 1'b0;
                logic_supply_low_flag_o <= 1'b0;
            end else if (limp_entry) begin
                supply_undervoltage_flag_o <= 1'b1;
                logic_supply_low_flag_o <= 1'b1;
            end else begin
                if (vs_uv_r)
                    supply_undervoltage_flag_o <= 1'b1;
                else if (soft_rst || (diag_readout_i && vs_op_r))
                    supply_undervoltage_flag_o <= 1'b0;
                if (vdd_lop_r)
                    logic_supply_low_flag_o <= 1'b1;
                else if (soft_rst || diag_readout_i)
                    logic_supply_low_flag_o <= 1'b0;
            end
        end
    end

    // First command after Limp entry reports a transmission error.
    // Later commands read the flag as normal again.
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            limp_first_r <= 1'b0;
            transmission_error_flag_o <= 1'b0;
        end else begin
            if (limp_entry)
                limp_first_r <= 1'b1;
            else if (spi_cmd_i || state_nxt != `OMC_ST_LIMP)
                limp_first_r <= 1'b0;
            if (state_nxt == `OMC_ST_SLEEP)
                transmission_error_flag_o <= 1'b0;
            else if (spi_cmd_i)
                transmission_error_flag_o <= limp_first_r;
        end
    end

endmodule

/* File: verif/omc_checker.sv */
// Concurrent checks on the ports of the operation mode controller.
`timescale 1ns/1ns
`include "omc_regs.vh"
module omc_checker (
    input wire clk_sys_i,
    input wire srst_i,
    input wire idle_pin_i,
    input wire [1:0] direct_input_pins_i,
    input wire vdd_uv_i,
    input wire reg_wr_i,
    input wire wr_soft_reset_bit_i,
    input wire spi_cmd_i,
    input wire [1:0] mode_o,
    input wire diag_enable_o,
    input wire [7:0] channel_on_o,
    input wire [7:0] output_on_bits_o,
    input wire stay_active_bit_o,
    input wire [7:0] input_mapping_a_o,
    input wire supply_undervoltage_flag_o,
    input wire logic_supply_low_flag_o,
    input wire transmission_error_flag_o,
    input wire open_load_on_flag_o,
    input wire open_load_off_flag_o
);
    wire m_li = mode_o == `OMC_MODE_LIMP;
    wire m_id = mode_o == `OMC_MODE_IDLE;
    wire m_ac = mode_o == `OMC_MODE_ACTIVE;
    wire hi = idle_pin_i && !vdd_uv_i;
    wire din = direct_input_pins_i != 2'h0;
    reg seen_r;
    // Remembers that a command has already been answered in this Limp Home stay.
    always @(posedge clk_sys_i) begin
        seen_r <= !srst_i && m_li && (seen_r || spi_cmd_i);
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    sequence s_limp_in; !m_li ##1 m_li; endsequence
    sequence s_quiet; (hi && !din)[*6]; endsequence
    property p_idle; m_id |-> channel_on_o == 8'h00 && !diag_enable_o; endproperty
    a_idle: assert property (p_idle) else $error("idle drives outputs");
    property p_limp; m_li |-> (channel_on_o & ~`OMC_LIMP_CH_MASK) == 8'h00
        && !open_load_on_flag_o && !open_load_off_flag_o; endproperty
    a_limp: assert property (p_limp) else $error("limp outputs wrong");
    property p_lflag; s_limp_in |-> ##[0:1] supply_undervoltage_flag_o
        && logic_supply_low_flag_o; endproperty
    a_lflag: assert property (p_lflag) else $error("limp flags not set");
    property p_ter; m_li && !seen_r && spi_cmd_i |-> ##[0:1] transmission_error_flag_o;
    endproperty
    a_ter: assert property (p_ter) else $error("first limp command not flagged");
    property p_srst; reg_wr_i && wr_soft_reset_bit_i && (m_id || m_ac) && hi |=>
        input_mapping_a_o == `OMC_MAP_A_RST && output_on_bits_o == 8'h00; endproperty
    a_srst: assert property (p_srst) else $error("soft reset ignored");
    property p_hold; hi[*6] ##0 (m_ac && stay_active_bit_o && !reg_wr_i) |=> m_ac;
    endproperty
    a_hold: assert property (p_hold) else $error("stay active lost");
    property p_quiet; s_quiet ##0 (m_ac && !stay_active_bit_o && !reg_wr_i
        && output_on_bits_o == 8'h00) |-> ##[1:3] m_id; endproperty
    a_quiet: assert property (p_quiet) else $error("no return to idle");
    property p_act; (hi && din)[*8] |-> ##[0:2] m_ac; endproperty
    a_act: assert property (p_act) else $error("no active entry");
endmodule
bind omc_mode_ctrl omc_checker u_chk (.*);

/* File: verif/omc_mcu.sv */
// Microcontroller model driving the pins, register writes, commands and readouts.
`timescale 1ns/1ns
module omc_mcu (
    input wire clk_sys_i,
    output reg idle_o = 0,
    output reg [1:0] din_o = 0,
    output reg [25:0] wd_o = 0,
    output reg [2:0] stb_o = 0
);
    task pins(input reg i, input reg [1:0] d);
        @(posedge clk_sys_i);
        #1 idle_o = i;
        din_o = d;
    endtask
    // Strobes wait for the mode to settle after a pin change.
    task send(input reg [2:0] k, input reg [25:0] d);
        repeat (8) @(posedge clk_sys_i);
        #1 stb_o = k;
        wd_o = d;
        @(posedge clk_sys_i);
        #1 stb_o = 3'h0;
        wd_o = ~d;
    endtask
endmodule

/* File: verif/omc_mode_ctrl_tb.sv */
// Self-checking bench for the operation mode controller.
`timescale 1ns/1ns
`include "omc_regs.vh"
module omc_mode_ctrl_tb;
    reg clk_sys_i = 0;
    reg srst_i = 1;
    reg vs_uv = 0, vs_op = 1, vdd_uv = 0, vdd_lop = 0, ol = 0, ter_seen = 0;
    reg [7:0] eset = 8'h00;
    wire idle;
    wire [1:0] din, mode;
    wire [2:0] stb;
    wire [25:0] wd;
    wire [7:0] ch, outb, mpa, mpb, err, osm;
    wire pwr, dgen, act, uvf, lpf, transmission_error_flag, open_load_on_flag, open_load_off_flag, spa;
    int fails = 0;
    int checked = 0;
    int cyc = 0;
    omc_mcu u_mcu (.clk_sys_i(clk_sys_i), .idle_o(idle), .din_o(din), .wd_o(wd), .stb_o(stb));
    omc_mode_ctrl u_dut (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .idle_pin_i(idle),
        .direct_input_pins_i(din), .vs_uv_i(vs_uv), .vs_op_i(vs_op),
        .vdd_uv_i(vdd_uv), .vdd_lop_i(vdd_lop), .reg_wr_i(stb[0]),
        .wr_output_on_bits_i(wd[25:18]), .wr_stay_active_bit_i(wd[17]),
        .wr_soft_reset_bit_i(wd[16]), .wr_input_mapping_a_i(wd[15:8]),
        .wr_input_mapping_b_i(wd[7:0]), .spi_cmd_i(stb[1]), .diag_readout_i(stb[2]),
        .channel_error_set_i(eset), .channel_error_clr_i(8'h00),
        .open_load_on_i(ol), .open_load_off_i(ol), .output_status_i(8'h5a),
        .mode_o(mode), .power_on_o(pwr), .diag_enable_o(dgen), .spi_access_o(spa),
        .channel_on_o(ch), .output_on_bits_o(outb), .stay_active_bit_o(act),
        .input_mapping_a_o(mpa), .input_mapping_b_o(mpb),
        .supply_undervoltage_flag_o(uvf), .logic_supply_low_flag_o(lpf),
        .transmission_error_flag_o(transmission_error_flag), .open_load_on_flag_o(open_load_on_flag),
        .open_load_off_flag_o(open_load_off_flag), .channel_error_latches_o(err),
        .output_status_monitor_bits_o(osm)
    );
    initial forever #25 clk_sys_i = ~clk_sys_i;
    task end_of_test;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (mode == `OMC_MODE_LIMP && transmission_error_flag === 1'b1) ter_seen <= 1'b1;
        if (cyc == 3000) begin
            fails++;
            end_of_test;
        end
    end
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task pin(input reg i, input reg [1:0] d);
        u_mcu.pins(i, d);
        tick(10);
    endtask
    task wr(input reg [7:0] o, input reg a, input reg r, input reg [7:0] ma, input reg [7:0] mb);
        u_mcu.send(3'h1, {o, a, r, ma, mb});
        tick(8);
    endtask
    initial begin
        tick(2);
        srst_i = 0;
        chk("mode", `OMC_MODE_SLEEP, mode);
        chk("map_a", `OMC_MAP_A_RST, mpa);
        chk("map_b", `OMC_MAP_B_RST, mpb);
        pin(1, 0);
        chk("mode", `OMC_MODE_IDLE, mode);
        chk("diag", 1'b0, dgen);
        chk("power", 1'b1, pwr);
        chk("spi", 1'b1, spa);
        wr(8'h81, 0, 0, 8'h04, 8'h08);
        chk("mode", `OMC_MODE_ACTIVE, mode);
        chk("chan", 8'h81, ch);
        wr(8'h00, 0, 0, 8'h00, 8'h00);
        chk("mode", `OMC_MODE_IDLE, mode);
        pin(1, 1);
        chk("mode", `OMC_MODE_ACTIVE, mode);
        chk("chan", 8'h00, ch);
        pin(1, 0);
        chk("mode", `OMC_MODE_IDLE, mode);
        wr(8'h00, 1, 0, 8'h04, 8'h08);
        chk("mode", `OMC_MODE_ACTIVE, mode);
        eset = 8'h20;
        vs_uv = 1;
        vs_op = 0;
        vdd_lop = 1;
        tick(1);
        eset = 8'h00;
        tick(8);
        chk("uv", 1'b1, uvf);
        chk("lop", 1'b1, lpf);
        vs_uv = 0;
        vs_op = 1;
        vdd_lop = 0;
        tick(8);
        chk("uv", 1'b1, uvf);
        u_mcu.send(3'h4, 26'h0);
        tick(4);
        chk("uv", 1'b0, uvf);
        chk("lop", 1'b0, lpf);
        vs_uv = 1;
        tick(8);
        vs_uv = 0;
        wr(8'h00, 0, 1, 8'h00, 8'h00);
        chk("uv", 1'b0, uvf);
        chk("map_a", `OMC_MAP_A_RST, mpa);
        chk("mode", `OMC_MODE_IDLE, mode);
        tick(20);
        chk("err", 8'h20, err);
        wr(8'h01, 0, 0, 8'h04, 8'h08);
        vdd_uv = 1;
        tick(10);
        chk("mode", `OMC_MODE_IDLE, mode);
        chk("out", 8'h00, outb);
        vdd_uv = 0;
        pin(0, 3);
        chk("mode", `OMC_MODE_LIMP, mode);
        chk("chan", 8'h0c, ch);
        chk("uv", 1'b1, uvf);
        chk("lop", 1'b1, lpf);
        chk("spi", 1'b1, spa);
        ol = 1;
        tick(4);
        chk("ol_on", 1'b0, open_load_on_flag);
        chk("ol_off", 1'b0, open_load_off_flag);
        chk("osm", 8'h5a, osm);
        u_mcu.send(3'h2, 26'h0);
        tick(1);
        chk("ter", 1'b1, ter_seen);
        u_mcu.send(3'h2, 26'h0);
        tick(1);
        chk("ter", 1'b0, transmission_error_flag);
        wr(8'hff, 1, 0, 8'h00, 8'h00);
        chk("out", 8'h00, outb);
        chk("act", 1'b0, act);
        pin(0, 0);
        chk("mode", `OMC_MODE_SLEEP, mode);
        chk("chan", 8'h00, ch);
        chk("err", 8'h00, err);
        chk("spi", 1'b0, spa);
        chk("power", 1'b0, pwr);
        end_of_test;
    end
endmodule
